// ### logic/asf_frame_if.sv
// Purpose: slave side of the converter serial frame link and its ready output
// Assumes: sclk_i idles low; master clock equals clk_sys_i; engine inputs are on clk_sys_i
// Notes:   hold words are refreshed only between frames, so they are quasi static to the link
`timescale 1ns/100ps
`include "asf_defs.svh"
// Summary of operation
// - mode 1: launch rising, sample falling edge
// - chip select high: ignore, float, reset
// - ready output low for data or detection
// - source field picks lagging, any, leading channel
// - global chop ignores the source field
// - first ready delayed when phase too low
// - phase boundary per oversampling ratio
// - float bit turns ready into open drain
// - level format or short pulse format
// - unread pulse drops the next result
// - no ready while readout in progress
// - word size 16/24/32, reset to 24
// - frame timeout after 2^15 clocks
// - command first, response next frame
// - standard frame of five words
// - multi-register commands lengthen the frame
// - control words MSB aligned, zero padded
// - samples truncated, padded or sign extended
// - samples are two's complement
// - per channel flags, status answers no-op
// - global chop: all data at ready
// - unknown command answered with status
module asf_frame_if #(
  parameter int RD_MAX  = 8,
  parameter int TMO_CYC = 2 ** `ASF_TMO_EXP
) (
  input  wire logic                clk_sys_i,
  input  wire logic                srst_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  output logic                     dout_o,
  output logic                     dout_oe_o,
  output logic                     conversion_ready_n_o,
  output logic                     conversion_ready_oe_o,
  input  wire logic [2:0]          chan_done_i,
  input  wire logic                cd_detect_i,
  input  wire logic                sync_pulse_i,
  input  wire logic                global_chop_i,
  input  wire asf_pkg::asf_sample_t chan_data_i [3],
  input  wire asf_pkg::asf_phase_t channel_phase_offset_i [3],
  input  wire logic [2:0]          oversampling_ratio_i,
  input  wire logic [1:0]          ready_source_select_i,
  input  wire logic                ready_idle_float_i,
  input  wire logic                ready_pulse_format_i,
  input  wire logic [1:0]          word_size_select_i,
  input  wire logic                timeout_en_i,
  input  wire logic [12:0]         status_hi_i,
  input  wire asf_pkg::asf_word_t  resp_word_i,
  input  wire asf_pkg::asf_word_t  crc_word_i,
  input  wire asf_pkg::asf_word_t  reg_rd_words_i [RD_MAX],
  output asf_pkg::asf_word_t       cmd_word_o,
  output logic                     cmd_valid_o,
  output asf_pkg::asf_word_t       wr_words_o [RD_MAX],
  output logic [3:0]               wr_count_o,
  output logic [2:0]               channel_ready_flags_o,
  output logic                     frame_timeout_o
);
  import asf_pkg::*;
  localparam int RW = $clog2(RD_MAX);
  localparam int TW = $clog2(TMO_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);
  localparam logic [2:0] PULSE_CYC = 3'(`ASF_PULSE_CYC);

  // link group: counters and receive shift, reset by select high or timeout
  logic [4:0]      bit_reg, bit_next, word_reg, word_next, flen, wl_last;
  asf_word_t       rx_reg, rx_next;
  logic [3:0]      wrx_reg, wrx_next;
  logic            ev_first, ev_done, ev_rd, last_bit;
  // event group on the link clock, reset only by system reset so toggles survive frames
  logic            first_tgl_reg, first_tgl_next, done_tgl_reg, done_tgl_next;
  logic            rd_tgl_reg, rd_tgl_next;
  asf_word_t       cmd_hold_reg, cmd_hold_next;
  logic [3:0]      wcnt_hold_reg, wcnt_hold_next;
  asf_word_t       wbuf_reg [RD_MAX];
  asf_word_t       wbuf_next [RD_MAX];
  // launch group
  logic            dout_next, doe_next;
  logic [31:0]     w32;
  // system group
  logic [1:0]      cs_sync_reg, cs_sync_next;
  logic [2:0]      f_sync_reg, f_sync_next, d_sync_reg, d_sync_next, r_sync_reg, r_sync_next;
  logic            link_rst, busy;
  logic            act_reg, act_next, nop_reg, nop_next;
  logic [TW-1:0]   tmo_cnt_reg, tmo_cnt_next;
  logic [1:0]      tmo_hold_reg, tmo_hold_next;
  logic            tmo_rst_reg, tmo_rst_next;
  asf_word_t       resp_h_reg, resp_h_next, crc_h_reg, crc_h_next;
  asf_sample_t     chan_h_reg [3];
  asf_sample_t     chan_h_next [3];
  asf_word_t       reg_h_reg [RD_MAX];
  asf_word_t       reg_h_next [RD_MAX];
  logic [3:0]      rdx_reg, rdx_next, rdx_pend_reg, rdx_pend_next;
  logic [1:0]      wl_reg, wl_next;
  asf_rdy_state_e  rs_reg, rs_next;
  logic [2:0]      pcnt_reg, pcnt_next;
  logic            unread_reg, unread_next, skip_reg, skip_next;
  logic [2:0]      flags_reg, flags_next;
  logic            rdy_n_next, rdy_oe_next, cmdv_next, fto_next;
  asf_word_t       cmd_o_next;
  asf_word_t       wr_o_next [RD_MAX];
  logic [3:0]      wr_cnt_next;
  logic            first_p, done_p, read_p, evt_ctrl, evt;
  logic [1:0]      lag_i, lead_i, ctl_i;
  logic [9:0]      bnd;
  logic            has_bnd;

  function automatic logic [31:0] fmt_sample(input asf_sample_t d, input logic [1:0] wl);
    unique case (wl)
      `ASF_WL_16:  fmt_sample = {d[23:8], 16'h0000};
      `ASF_WL_24:  fmt_sample = {d, 8'h00};
      `ASF_WL_32Z: fmt_sample = {d, 8'h00};
      `ASF_WL_32S: fmt_sample = {{8{d[23]}}, d};
    endcase
  endfunction

  assign link_rst = cs_n_i | tmo_rst_reg | srst_i;

  always_comb begin
    wl_last  = (wl_reg == `ASF_WL_16) ? 5'd15 : (wl_reg == `ASF_WL_24) ? 5'd23 : 5'd31;
    flen     = `ASF_STD_WORDS + {1'b0, rdx_reg} + {1'b0, wrx_reg};
    last_bit = (bit_reg == wl_last);
    rx_next  = (bit_reg < 5'd16) ? {rx_reg[14:0], din_i} : rx_reg;
    bit_next = last_bit ? 5'd0 : bit_reg + 5'd1;
    word_next = word_reg;
    wrx_next = wrx_reg;
    ev_first = (bit_reg == 5'd0) && (word_reg == 5'd0);
    ev_done  = last_bit && (word_reg == flen - 5'd1);
    ev_rd    = last_bit && (word_reg == {1'b0, rdx_reg} + 5'd3);
    if (last_bit) begin
      word_next = ev_done ? 5'd0 : word_reg + 5'd1;
      if ((word_reg == 5'd0) && (rx_next[15:13] == `ASF_OP_WR)) begin
        wrx_next = (rx_next[6:0] > 7'(RD_MAX - 1)) ? 4'(RD_MAX - 1) : rx_next[3:0];
      end
    end
  end

  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_reg  <= 5'd0;
      word_reg <= 5'd0;
      rx_reg   <= 16'h0000;
      wrx_reg  <= 4'h0;
    end else begin
      bit_reg  <= bit_next;
      word_reg <= word_next;
      rx_reg   <= rx_next;
      wrx_reg  <= wrx_next;
    end
  end

  always_comb begin
    first_tgl_next = first_tgl_reg ^ ev_first;
    done_tgl_next  = done_tgl_reg ^ ev_done;
    rd_tgl_next    = rd_tgl_reg ^ ev_rd;
    cmd_hold_next  = cmd_hold_reg;
    wcnt_hold_next = wcnt_hold_reg;
    for (int i = 0; i < RD_MAX; i++) begin
      wbuf_next[i] = wbuf_reg[i];
    end
    if (last_bit && (word_reg == 5'd0)) begin
      cmd_hold_next  = rx_next;
      wcnt_hold_next = 4'h0;
    end
    if (last_bit && (word_reg != 5'd0) && (word_reg <= {1'b0, wrx_reg} + 5'd1)) begin
      wbuf_next[RW'(word_reg - 5'd1)] = rx_next;
      wcnt_hold_next = word_reg[3:0];
    end
  end

  always_ff @(negedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      first_tgl_reg <= 1'b0;
      done_tgl_reg  <= 1'b0;
      rd_tgl_reg    <= 1'b0;
      cmd_hold_reg  <= 16'h0000;
      wcnt_hold_reg <= 4'h0;
      for (int i = 0; i < RD_MAX; i++) begin
        wbuf_reg[i] <= 16'h0000;
      end
    end else begin
      first_tgl_reg <= first_tgl_next;
      done_tgl_reg  <= done_tgl_next;
      rd_tgl_reg    <= rd_tgl_next;
      cmd_hold_reg  <= cmd_hold_next;
      wcnt_hold_reg <= wcnt_hold_next;
      wbuf_reg      <= wbuf_next;
    end
  end

  // word picked from counters the falling edge left behind
  always_comb begin
    if (word_reg == 5'd0) begin
      w32 = {resp_h_reg, 16'h0000};
    end else if (word_reg <= {1'b0, rdx_reg}) begin
      w32 = {reg_h_reg[RW'(word_reg - 5'd1)], 16'h0000};
    end else if (word_reg <= {1'b0, rdx_reg} + 5'd3) begin
      w32 = fmt_sample(chan_h_reg[2'(word_reg - {1'b0, rdx_reg} - 5'd1)], wl_reg);
    end else if (word_reg == flen - 5'd1) begin
      w32 = {crc_h_reg, 16'h0000};
    end else begin
      w32 = 32'h0000_0000;
    end
    dout_next = w32[5'd31 - bit_reg];
    doe_next  = 1'b1;
  end

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else begin
      dout_o    <= dout_next;
      dout_oe_o <= doe_next;
    end
  end

  // ready source: lagging is the largest signed phase, leading the smallest
  always_comb begin
    lag_i  = 2'd0;
    lead_i = 2'd0;
    for (int i = 1; i < 3; i++) begin
      if ($signed(channel_phase_offset_i[i]) > $signed(channel_phase_offset_i[lag_i])) lag_i = 2'(i);
      if ($signed(channel_phase_offset_i[i]) < $signed(channel_phase_offset_i[lead_i])) lead_i = 2'(i);
    end
    ctl_i = (ready_source_select_i == `ASF_SEL_LAG) ? lag_i : lead_i;
    has_bnd = 1'b1;
    unique case (oversampling_ratio_i)
      `ASF_OSR_64:   bnd = `ASF_BND_64;
      `ASF_OSR_128:  bnd = `ASF_BND_128;
      `ASF_OSR_256:  bnd = `ASF_BND_256;
      `ASF_OSR_512:  bnd = `ASF_BND_512;
      `ASF_OSR_1024: bnd = `ASF_BND_1024;
      default: begin
        bnd     = 10'h000;
        has_bnd = 1'b0;
      end
    endcase
  end

  always_comb begin
    cs_sync_next = {cs_sync_reg[0], cs_n_i};
    f_sync_next  = {f_sync_reg[1:0], first_tgl_reg};
    d_sync_next  = {d_sync_reg[1:0], done_tgl_reg};
    r_sync_next  = {r_sync_reg[1:0], rd_tgl_reg};
    first_p = f_sync_reg[2] ^ f_sync_reg[1];
    done_p  = d_sync_reg[2] ^ d_sync_reg[1];
    read_p  = r_sync_reg[2] ^ r_sync_reg[1];
    busy    = act_reg || !cs_sync_reg[1];
    act_next = (act_reg || first_p) && !done_p && !cs_sync_reg[1];
    // frame timeout counts from the first falling clock edge of a frame
    tmo_cnt_next  = act_reg ? tmo_cnt_reg + TW'(1) : '0;
    tmo_rst_next  = 1'b0;
    tmo_hold_next = (tmo_hold_reg != 2'd0) ? tmo_hold_reg - 2'd1 : 2'd0;
    fto_next = 1'b0;
    if (act_reg && timeout_en_i && (tmo_cnt_reg == TMO_LAST)) begin
      tmo_hold_next = `ASF_TMO_HOLD;
      fto_next = 1'b1;
      act_next = 1'b0;
    end
    if (tmo_hold_next != 2'd0) tmo_rst_next = 1'b1;
    cmdv_next   = done_p;
    cmd_o_next  = done_p ? cmd_hold_reg : cmd_word_o;
    wr_o_next   = wr_words_o;
    if (done_p) wr_o_next = wbuf_reg;
    wr_cnt_next = done_p ? wcnt_hold_reg : wr_count_o;
    nop_next = nop_reg;
    rdx_pend_next = rdx_pend_reg;
    if (done_p) begin
      unique case (cmd_hold_reg)
        `ASF_CMD_RESET, `ASF_CMD_STANDBY, `ASF_CMD_WAKEUP, `ASF_CMD_LOCK, `ASF_CMD_UNLOCK: nop_next = 1'b0;
        default: nop_next = !(cmd_hold_reg[15:13] == `ASF_OP_RD || cmd_hold_reg[15:13] == `ASF_OP_WR);
      endcase
      rdx_pend_next = 4'h0;
      if (cmd_hold_reg[15:13] == `ASF_OP_RD && cmd_hold_reg[6:0] != 7'h00) begin
        rdx_pend_next = (cmd_hold_reg[6:0] > 7'(RD_MAX - 1)) ? 4'(RD_MAX) : cmd_hold_reg[3:0] + 4'h1;
      end
    end
    // refresh the link's hold words only while no frame runs
    resp_h_next = resp_h_reg;
    crc_h_next  = crc_h_reg;
    chan_h_next = chan_h_reg;
    reg_h_next  = reg_h_reg;
    rdx_next    = rdx_reg;
    wl_next     = wl_reg;
    if (!busy && !first_p) begin
      resp_h_next = nop_reg ? {status_hi_i, flags_reg} : resp_word_i;
      crc_h_next  = crc_word_i;
      chan_h_next = chan_data_i;
      reg_h_next  = reg_rd_words_i;
      rdx_next    = rdx_pend_reg;
      wl_next     = word_size_select_i;
    end
    flags_next = (flags_reg & ~{3{read_p}}) | chan_done_i;
    // first ready after sync is held back when the phase sits at or under the boundary
    evt_ctrl = (global_chop_i || ready_source_select_i == `ASF_SEL_ANY) ? |chan_done_i : chan_done_i[ctl_i];
    skip_next = skip_reg && !evt_ctrl;
    if (sync_pulse_i) begin
      skip_next = !global_chop_i && has_bnd && ($signed(channel_phase_offset_i[ctl_i]) <= $signed(bnd));
    end
    evt = (evt_ctrl && !skip_reg) || cd_detect_i;
    rs_next     = rs_reg;
    pcnt_next   = (pcnt_reg != 3'd0) ? pcnt_reg - 3'd1 : 3'd0;
    unread_next = unread_reg && !read_p;
    unique case (rs_reg)
      ASF_RDY_IDLE: begin
        if (evt && !busy) begin
          if (!ready_pulse_format_i) begin
            rs_next = ASF_RDY_LOW;
          end else if (unread_reg) begin
            unread_next = 1'b0;
          end else begin
            rs_next     = ASF_RDY_PULSE;
            pcnt_next   = PULSE_CYC - 3'd1;
            unread_next = 1'b1;
          end
        end
      end
      ASF_RDY_LOW: begin
        if (evt && !busy) begin
          rs_next = ASF_RDY_BLIP;
        end else if (read_p) begin
          rs_next = ASF_RDY_IDLE;
        end
      end
      ASF_RDY_BLIP: rs_next = ASF_RDY_LOW;
      ASF_RDY_PULSE: begin
        if (pcnt_reg == 3'd0) rs_next = ASF_RDY_IDLE;
      end
    endcase
    rdy_n_next  = !(rs_next == ASF_RDY_LOW || rs_next == ASF_RDY_PULSE);
    rdy_oe_next = ready_idle_float_i ? !rdy_n_next : 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cs_sync_reg <= 2'b11;
      f_sync_reg  <= 3'b000;
      d_sync_reg  <= 3'b000;
      r_sync_reg  <= 3'b000;
      act_reg     <= 1'b0;
      tmo_cnt_reg <= '0;
      tmo_hold_reg <= 2'd0;
      tmo_rst_reg <= 1'b0;
      frame_timeout_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_word_o  <= 16'h0000;
      wr_count_o  <= 4'h0;
      nop_reg     <= 1'b1;
      rdx_pend_reg <= 4'h0;
      rdx_reg     <= 4'h0;
      resp_h_reg  <= 16'h0000;
      crc_h_reg   <= 16'h0000;
      wl_reg      <= `ASF_WL_RESET;
      flags_reg   <= 3'b000;
      skip_reg    <= 1'b0;
      rs_reg      <= ASF_RDY_IDLE;
      pcnt_reg    <= 3'd0;
      unread_reg  <= 1'b0;
      conversion_ready_n_o  <= 1'b1;
      conversion_ready_oe_o <= 1'b1;
      for (int i = 0; i < RD_MAX; i++) begin
        reg_h_reg[i]  <= 16'h0000;
        wr_words_o[i] <= 16'h0000;
      end
      for (int i = 0; i < 3; i++) begin
        chan_h_reg[i] <= 24'h000000;
      end
    end else begin
      cs_sync_reg <= cs_sync_next;
      f_sync_reg  <= f_sync_next;
      d_sync_reg  <= d_sync_next;
      r_sync_reg  <= r_sync_next;
      act_reg     <= act_next;
      tmo_cnt_reg <= tmo_cnt_next;
      tmo_hold_reg <= tmo_hold_next;
      tmo_rst_reg <= tmo_rst_next;
      frame_timeout_o <= fto_next;
      cmd_valid_o <= cmdv_next;
      cmd_word_o  <= cmd_o_next;
      wr_count_o  <= wr_cnt_next;
      nop_reg     <= nop_next;
      rdx_pend_reg <= rdx_pend_next;
      rdx_reg     <= rdx_next;
      resp_h_reg  <= resp_h_next;
      crc_h_reg   <= crc_h_next;
      wl_reg      <= wl_next;
      flags_reg   <= flags_next;
      skip_reg    <= skip_next;
      rs_reg      <= rs_next;
      pcnt_reg    <= pcnt_next;
      unread_reg  <= unread_next;
      conversion_ready_n_o  <= rdy_n_next;
      conversion_ready_oe_o <= rdy_oe_next;
      reg_h_reg   <= reg_h_next;
      wr_words_o  <= wr_o_next;
      chan_h_reg  <= chan_h_next;
    end
  end

  assign channel_ready_flags_o = flags_reg;

  chk_pulse_width: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rs_reg == ASF_RDY_IDLE && rs_next == ASF_RDY_PULSE) |=> (!conversion_ready_n_o)[*2] ##1 conversion_ready_n_o)
    else $error("ready pulse width wrong");
  chk_float_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (ready_idle_float_i && $stable(ready_idle_float_i)) |=> (conversion_ready_oe_o == !conversion_ready_n_o))
    else $error("floating ready drives high");
  chk_busy_block: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (evt && busy && rs_reg == ASF_RDY_IDLE) |=> conversion_ready_n_o)
    else $error("ready asserted during readout");
  chk_flag_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    chan_done_i[1] |=> channel_ready_flags_o[1] ##1 (channel_ready_flags_o[1] || $past(read_p)))
    else $error("channel flag lost");
  chk_nop_status: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (nop_reg && !busy && !first_p) |=> (resp_h_reg == {$past(status_hi_i), $past(flags_reg)}))
    else $error("no-op answer is not status");
  chk_wl_reset: assert property (@(posedge clk_sys_i) srst_i |=> (wl_reg == `ASF_WL_RESET))
    else $error("word size not 24 after reset");
  chk_timeout_fire: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (act_reg && timeout_en_i && tmo_cnt_reg == TMO_LAST) |=> (tmo_rst_reg && frame_timeout_o) ##1 tmo_rst_reg ##1 !tmo_rst_reg)
    else $error("timeout reset not issued");
  chk_level_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rs_reg == ASF_RDY_LOW && !read_p && !(evt && !busy)) |=> !conversion_ready_n_o)
    else $error("level ready released early");
  chk_dout_float: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cs_n_i && $past(cs_n_i)) |-> !dout_oe_o)
    else $error("output driven while deselected");
  chk_skip_first: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (skip_reg && evt_ctrl && !cd_detect_i && rs_reg == ASF_RDY_IDLE) |=> conversion_ready_n_o ##1 !skip_reg)
    else $error("first ready not held back");
endmodule

// ### shared/asf_defs.svh
// Purpose: constants of the converter serial frame interface
// Assumes: included by its bare name
// Notes:   widths are sized to what they meet
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
`define ASF_WL_16        2'b00
`define ASF_WL_24        2'b01
`define ASF_WL_32Z       2'b10
`define ASF_WL_32S       2'b11
`define ASF_WL_RESET     2'b01
`define ASF_STD_WORDS    5'd5
`define ASF_CH_WORDS     4'd3
`define ASF_TMO_EXP      15
`define ASF_TMO_HOLD     2'd2
`define ASF_CLK_NS       4
`define ASF_PULSE_NS     8
`define ASF_PULSE_CYC    (((`ASF_PULSE_NS) + (`ASF_CLK_NS) - 1) / (`ASF_CLK_NS))
`define ASF_SEL_LAG      2'b00
`define ASF_SEL_ANY      2'b01
`define ASF_OSR_64       3'd0
`define ASF_OSR_128      3'd1
`define ASF_OSR_256      3'd2
`define ASF_OSR_512      3'd3
`define ASF_OSR_1024     3'd4
`define ASF_BND_64       10'h00d
`define ASF_BND_128      10'h3ed
`define ASF_BND_256      10'h3ad
`define ASF_BND_512      10'h32d
`define ASF_BND_1024     10'h22d
`define ASF_CMD_NOP      16'h0000
`define ASF_CMD_RESET    16'h0011
`define ASF_CMD_STANDBY  16'h0022
`define ASF_CMD_WAKEUP   16'h0033
`define ASF_CMD_LOCK     16'h0555
`define ASF_CMD_UNLOCK   16'h0655
`define ASF_OP_RD        3'b101
`define ASF_OP_WR        3'b011
`endif

// ### shared/asf_pkg.sv
// Purpose: types of the converter serial frame interface
// Assumes: nothing
// Notes:   constants live in asf_defs.svh
package asf_pkg;
  typedef enum logic [1:0] {
    ASF_RDY_IDLE  = 2'b00,
    ASF_RDY_LOW   = 2'b01,
    ASF_RDY_BLIP  = 2'b11,
    ASF_RDY_PULSE = 2'b10
  } asf_rdy_state_e;
  typedef logic [15:0] asf_word_t;
  typedef logic [23:0] asf_sample_t;
  typedef logic [9:0]  asf_phase_t;
endpackage

// ### tb/asf_host_model.sv
// Purpose: host side of the serial frame link, bus master in mode 1
// Assumes: link clock of 6 ns runs only inside a frame
// Notes:   captured words sit right aligned in rx for the bench to read
`timescale 1ns/100ps
module asf_host_model (
  input  wire logic dout_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  logic [31:0] rx [8];
  logic [15:0] wd [8];
  initial begin
    foreach (wd[i]) wd[i] = 16'h0000;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b1;
  end
  // one frame of nw words of nb bits, command in word 0, words from wd after
  task automatic run_frame(input int nw, input int nb, input logic [15:0] cmd);
    logic [31:0] tx;
    #1.3 cs_n_o = 1'b0;
    #20;
    for (int w = 0; w < nw; w++) begin
      tx = {16'h0, (w == 0) ? cmd : wd[w]} << (nb - 16);
      rx[w] = 32'h0;
      for (int b = nb - 1; b >= 0; b--) begin
        sclk_o = 1'b1;
        din_o = tx[b];
        #3 sclk_o = 1'b0;
        rx[w][b] = dout_i;
        #3;
      end
    end
    #3 cs_n_o = 1'b1;
    din_o = ~din_o;  // a released line must not keep its last value
  endtask
endmodule

// ### tb/adc_spi_frame_interface_tb_top.sv
// Purpose: self-checking bench of the converter serial frame interface
// Assumes: the host model is the only bus master on the link
// Notes:   commands are scored as cmd_valid_o reports them
`timescale 1ns/100ps
`include "asf_defs.svh"
module adc_spi_frame_interface_tb_top;
  import asf_pkg::*;
  logic clk_sys_i, srst_i, sclk, cs_n, din, dout, dout_oe, rdy_n, rdy_oe, cmd_valid, flt, fmt, tmo;
  logic sync, gc, tmo_en;
  logic [2:0] done, flags;
  logic [1:0] sel, ws;
  logic [12:0] st_hi;
  logic [3:0] wr_count;
  asf_word_t resp, crc, cmd_word;
  asf_word_t rd_w [8];
  asf_word_t wr_w [8];
  asf_sample_t data [3];
  asf_phase_t phase [3];
  asf_word_t exp_q [$];
  int mismatches, tests_run, nb, n, fw, n_tmo;
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // a released output line shows the inverse, so a missing enable is caught
  asf_host_model i_host (.dout_i(dout_oe ? dout : ~dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  asf_frame_if #(.RD_MAX(8), .TMO_CYC(64)) i_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .dout_oe_o(dout_oe), .conversion_ready_n_o(rdy_n), .conversion_ready_oe_o(rdy_oe),
    .chan_done_i(done), .cd_detect_i(1'b0), .sync_pulse_i(sync), .global_chop_i(gc),
    .chan_data_i(data), .channel_phase_offset_i(phase), .oversampling_ratio_i(3'd0),
    .ready_source_select_i(sel), .ready_idle_float_i(flt), .ready_pulse_format_i(fmt),
    .word_size_select_i(ws), .timeout_en_i(tmo_en), .status_hi_i(st_hi), .resp_word_i(resp),
    .crc_word_i(crc), .reg_rd_words_i(rd_w), .cmd_word_o(cmd_word), .cmd_valid_o(cmd_valid),
    .wr_words_o(wr_w), .wr_count_o(wr_count), .channel_ready_flags_o(flags), .frame_timeout_o(tmo));
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d of %0d comparisons", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] ctl(input logic [15:0] v);
    return {16'h0, v} << (nb - 16);
  endfunction
  function automatic logic [31:0] smp(input logic [23:0] d);
    case (ws)
      `ASF_WL_16: smp = {16'h0, d[23:8]};
      `ASF_WL_24: smp = {8'h0, d};
      `ASF_WL_32Z: smp = {d, 8'h0};
      default: smp = {{8{d[23]}}, d};
    endcase
  endfunction
  task automatic do_frame(input logic [15:0] cmd);
    exp_q.push_back(cmd);
    i_host.run_frame(fw, nb, cmd);
    repeat (12) @(negedge clk_sys_i);
  endtask
  task automatic pulse_event(input logic [2:0] ch);
    done = ch;
    @(negedge clk_sys_i);
    done = 3'b000;
  endtask
  task automatic count_low(output int cnt);
    cnt = 0;
    repeat (8) begin
      if (rdy_n === 1'b0) cnt++;
      @(negedge clk_sys_i);
    end
  endtask
  // the scoreboard side: each reported command takes the oldest note
  always @(negedge clk_sys_i) begin
    if (cmd_valid === 1'b1) check(cmd_word, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    if (tmo === 1'b1) n_tmo++;
  end
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    void'($urandom(31704));
    srst_i = 1'b1;
    done = 3'b000;
    {sel, flt, fmt, ws, nb} = {2'b01, 1'b0, 1'b1, `ASF_WL_24, 24};
    {st_hi, resp, crc} = 45'({$urandom, $urandom});
    {sync, gc, tmo_en} = 3'b000;
    fw = 5;
    phase = '{10'h005, 10'h000, 10'h3fd};
    foreach (rd_w[i]) rd_w[i] = 16'($urandom);
    foreach (data[i]) data[i] = 24'($urandom);
    repeat (12) @(negedge clk_sys_i);
    check({rdy_n, rdy_oe, flags, dout_oe}, 6'b110000);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    do_frame(`ASF_CMD_NOP);
    do_frame(16'h1234);
    check(i_host.rx[0], ctl({st_hi, 3'b000}));
    do_frame(`ASF_CMD_NOP);
    check(i_host.rx[0], ctl({st_hi, 3'b000}));
    check(dout_oe, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ws = 2'(k);
      nb = (k == 0) ? 16 : (k == 1) ? 24 : 32;
      foreach (data[i]) data[i] = 24'($urandom);
      crc = 16'($urandom);
      repeat (12) @(negedge clk_sys_i);
      do_frame(`ASF_CMD_NOP);
      check(i_host.rx[0], ctl({st_hi, 3'b000}));
      for (int c = 0; c < 3; c++) check(i_host.rx[c + 1], smp(data[c]));
      check(i_host.rx[4], ctl(crc));
    end
    // read of three registers, answered in a lengthened next frame
    do_frame(16'ha002);
    fw = 8;
    do_frame(`ASF_CMD_NOP);
    check(i_host.rx[0], ctl(resp));
    for (int r = 0; r < 3; r++) check(i_host.rx[r + 1], ctl(rd_w[r]));
    check(i_host.rx[7], ctl(crc));
    fw = 6;
    i_host.wd[1] = 16'($urandom);
    i_host.wd[2] = 16'($urandom);
    do_frame(16'h6001);
    check(wr_count, 2);
    check(wr_w[0], i_host.wd[1]);
    check(wr_w[1], i_host.wd[2]);
    fw = 5;
    i_host.wd[1] = 16'h0000;
    i_host.wd[2] = 16'h0000;
    {fmt, flt} = 2'b01;
    for (int k = 0; k < 5; k++) begin
      sel = (k == 1) ? 2'b10 : (k == 2) ? `ASF_SEL_ANY : `ASF_SEL_LAG;
      gc = (k == 3);
      sync = (k == 4);
      @(negedge clk_sys_i);
      sync = 1'b0;
      pulse_event((k == 0) ? 3'b100 : (k == 1 || k == 4) ? 3'b001 : 3'b000);
      repeat (4) @(negedge clk_sys_i);
      check(rdy_n, 1'b1);
      pulse_event((k == 0 || k == 4) ? 3'b001 : (k == 2) ? 3'b010 : 3'b100);
      repeat (4) @(negedge clk_sys_i);
      check({rdy_n, rdy_oe}, 2'b01);
      do_frame(`ASF_CMD_NOP);
      check({rdy_n, rdy_oe}, 2'b10);
    end
    {fmt, flt, sel} = {1'b1, 1'b0, `ASF_SEL_ANY};
    pulse_event(3'b111);
    count_low(n);
    check(n, 2);
    check(flags, 3'b111);
    pulse_event(3'b111);
    count_low(n);
    check(n, 0);
    pulse_event(3'b111);
    count_low(n);
    check(n, 2);
    do_frame(`ASF_CMD_NOP);
    check(flags, 3'b000);
    fork
      do_frame(`ASF_CMD_NOP);
      begin
        #200;
        @(negedge clk_sys_i);
        pulse_event(3'b111);
        count_low(n);
        check(n, 0);
      end
    join
    // cut frames never finish, so no command is reported for them
    for (int e = 0; e < 2; e++) begin
      tmo_en = e[0];
      i_host.run_frame(2, nb, `ASF_CMD_NOP);
      repeat (12) @(negedge clk_sys_i);
      check(n_tmo, e);
    end
    check(exp_q.size(), 0);
    end_of_test();
  end
endmodule
